/* design/cmp_pkg.sv */
// shared constants and types of the converter and power-down control
package cmp_pkg;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_ALERT  = 8'h04;
  localparam logic [7:0] ADDR_PDTMR  = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_START  = 8'h10;
  localparam logic [7:0] ADDR_RES    = 8'h40;
  localparam int         NUM_RES     = 13;

  // control field positions
  localparam int CTRL_CONV_LSB = 14;
  localparam int CTRL_RB_LSB   = 12;
  localparam int CTRL_AVG_LSB  = 9;
  localparam int CTRL_SWPD     = 8;
  localparam int CTRL_ACQ_LSB  = 5;
  localparam int CTRL_TERM     = 3;

  // values after reset
  localparam logic [15:0] CTRL_RST  = 16'h0000;
  localparam logic [7:0]  ALERT_RST = 8'h00;
  localparam logic [4:0]  PDTMR_RST = 5'h00;
  localparam logic [2:0]  SYNC_RST  = 3'h3;

  // timing
  localparam int    CLK_MHZ      = 200;
  localparam int    PD_LOW_US    = 150;
  localparam int    PD_HIGH_US   = 5;
  localparam int    PD_LOW_CYC   = PD_LOW_US * CLK_MHZ;
  localparam int    PD_HIGH_CYC  = PD_HIGH_US * CLK_MHZ;
  localparam int    TICK_S       = 75;
  localparam int    CTRL_CLK_HZ  = 6250000;
  localparam longint TICK_EDGES  = longint'(TICK_S) * CTRL_CLK_HZ;

  // channel indices of the result store
  localparam logic [3:0] CH_V6   = 4'h5;
  localparam logic [3:0] CH_T1   = 4'h6;
  localparam logic [3:0] CH_T6   = 4'hb;
  localparam logic [3:0] CH_SELF = 4'hc;
  localparam logic [3:0] CH_NONE = 4'hf;

  // conversion-select codes
  localparam logic [1:0] CONV_ALL  = 2'h0;
  localparam logic [1:0] CONV_ODD  = 2'h1;
  localparam logic [1:0] CONV_VOLT = 2'h2;
  localparam logic [1:0] CONV_SELF = 2'h3;

  typedef enum logic [1:0] {SQ_IDLE, SQ_ISSUE, SQ_WAIT} cmp_seq_state_t;

  typedef struct packed {
    logic       start;
    logic [3:0] channel;
    logic [1:0] acq;
  } cmp_adc_req_t;

endpackage

/* design/cmp_conv_power_ctrl.sv */
// converter sequencer, averaging and power-down control with apb registers
// Function
// - avg field selects 1, 2, 4 or 8 conversions per input, default 1.
// - averaged result stored per channel and read back like single result.
// - all repetitions on one channel finish before the next channel.
// - all six voltage channels converted in every mode but self-test, and always readable.
// - conversion field selects six, odd three, or no thermistor inputs.
// - separate readback field sets how many results are supplied.
// - alert config low bits drop thermistor inputs 5 and 3 from faults.
// - power-down pin low about 150 us before full power-down.
// - full power-down left after pin high about 5 us.
// - software bit powers down most circuitry; regulator and chain stay.
// - delay timer 0 to 38.75 minutes in 75 second steps.
// - request starts the timer, expiry powers down; timer resets to zero.
// - conversion codes 00 all, 01 odd thermistors, 10 volts, 11 self-test.
// - acquisition field 400 ns to 1.6 us, default 400 ns.
// - zero timer gives immediate power-down and balance outputs off.
`timescale 1ns/1ps
module cmp_conv_power_ctrl #(
  parameter int     PD_LOW_CYCLES = cmp_pkg::PD_LOW_CYC,
  parameter longint TICK_EDGES    = cmp_pkg::TICK_EDGES
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic [7:0]            paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  power_down_n_pin,
  input  wire logic                  convert_start_n_pin,
  input  wire logic                  ctrl_clk,
  input  wire logic                  adc_done,
  input  wire logic [11:0]           adc_data,
  output cmp_pkg::cmp_adc_req_t      adc_req,
  output logic                       conv_busy,
  output logic                       thermistor_common_termination,
  output logic [5:0]                 thermistor_alert_exclude,
  output logic                       full_power_down,
  output logic                       soft_power_down,
  output logic                       balance_off
);

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a[1:0] == 2'h0) &&
              ((a <= cmp_pkg::ADDR_START) ||
               ((a >= cmp_pkg::ADDR_RES) &&
                (a < cmp_pkg::ADDR_RES + 8'(4 * cmp_pkg::NUM_RES))));
  endfunction

  // results beyond the readback selection read as zero
  function automatic logic rb_ok(input logic [3:0] ch, input logic [1:0] rb);
    if (ch < cmp_pkg::CH_T1 || ch == cmp_pkg::CH_SELF)
      rb_ok = 1'b1;
    else if (rb == cmp_pkg::CONV_ALL)
      rb_ok = 1'b1;
    else if (rb == cmp_pkg::CONV_ODD)
      rb_ok = (ch[0] == 1'b0);
    else
      rb_ok = 1'b0;
  endfunction

  // channel order: voltage 6 down to 1, then thermistors
  function automatic logic [3:0] next_ch(input logic [3:0] ch,
                                         input logic [1:0] sel);
    if (ch == cmp_pkg::CH_SELF || ch >= cmp_pkg::CH_T6)
      next_ch = cmp_pkg::CH_NONE;
    else if (ch > 4'h0 && ch < cmp_pkg::CH_T1)
      next_ch = ch - 4'h1;
    else if (ch == 4'h0)
      next_ch = (sel == cmp_pkg::CONV_VOLT) ? cmp_pkg::CH_NONE
                                            : cmp_pkg::CH_T1;
    else if (sel == cmp_pkg::CONV_ODD)
      next_ch = (ch >= 4'ha) ? cmp_pkg::CH_NONE : ch + 4'h2;
    else
      next_ch = ch + 4'h1;
  endfunction

  // pin synchronisers: bit 0 power-down, 1 convert start, 2 control clock
  logic [2:0] sync1, sync2, sync3;
  logic [2:0] next_sync1, next_sync2, next_sync3;

  always_comb begin
    next_sync1 = {ctrl_clk, convert_start_n_pin, power_down_n_pin};
    next_sync2 = sync1;
    next_sync3 = sync2;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= cmp_pkg::SYNC_RST;
      sync2 <= cmp_pkg::SYNC_RST;
      sync3 <= cmp_pkg::SYNC_RST;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      sync3 <= next_sync3;
    end
  end

  logic convert_start_n_pin_fall, ctrl_rise;
  assign convert_start_n_pin_fall = sync3[1] & ~sync2[1];
  assign ctrl_rise  = sync2[2] & ~sync3[2];

  // power-down pin glitch filter
  logic        pd_low_f, next_pd_low_f;
  logic [31:0] flt_cnt, next_flt_cnt;

  always_comb begin
    next_pd_low_f = pd_low_f;
    next_flt_cnt  = 32'h0;
    if (~sync2[0] != pd_low_f) begin
      // entry after long low, exit after short high
      if (flt_cnt == (pd_low_f ? 32'(cmp_pkg::PD_HIGH_CYC - 1)
                               : 32'(PD_LOW_CYCLES - 1)))
        next_pd_low_f = ~pd_low_f;
      else
        next_flt_cnt = flt_cnt + 32'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_low_f <= 1'b0;
      flt_cnt  <= 32'h0;
    end else begin
      pd_low_f <= next_pd_low_f;
      flt_cnt  <= next_flt_cnt;
    end
  end

  logic hw_req, hw_rel;
  assign hw_req = next_pd_low_f & ~pd_low_f;
  assign hw_rel = pd_low_f & ~next_pd_low_f;

  // apb register file
  logic [15:0] ctrl, next_ctrl;
  logic [7:0]  alert, next_alert;
  logic [4:0]  pdtmr, next_pdtmr;
  logic [31:0] rdata, next_rdata;
  logic        start_wr, next_start_wr;
  logic        sw_req;
  logic [11:0] res [cmp_pkg::NUM_RES];
  logic        wr_en, rd_setup;
  logic [3:0]  rd_ch;
  logic        pwr_pend, next_pwr_pend;

  assign wr_en    = psel & penable & pwrite & addr_ok(paddr);
  assign rd_setup = psel & ~penable & ~pwrite;
  assign rd_ch    = 4'((paddr - cmp_pkg::ADDR_RES) >> 2);
  assign sw_req   = next_ctrl[cmp_pkg::CTRL_SWPD] &
                    ~ctrl[cmp_pkg::CTRL_SWPD];

  always_comb begin
    next_ctrl     = ctrl;
    next_alert    = alert;
    next_pdtmr    = pdtmr;
    next_rdata    = rdata;
    next_start_wr = 1'b0;
    if (wr_en) begin
      case (paddr)
        cmp_pkg::ADDR_CTRL:  next_ctrl = pwdata[15:0];
        cmp_pkg::ADDR_ALERT: next_alert = pwdata[7:0];
        cmp_pkg::ADDR_PDTMR: next_pdtmr = pwdata[4:0];
        cmp_pkg::ADDR_START: next_start_wr = pwdata[0];
        default:             next_ctrl = ctrl;
      endcase
    end
    if (rd_setup) begin
      next_rdata = 32'h0;
      if (addr_ok(paddr)) begin
        case (paddr)
          cmp_pkg::ADDR_CTRL:   next_rdata = {16'h0, ctrl};
          cmp_pkg::ADDR_ALERT:  next_rdata = {24'h0, alert};
          cmp_pkg::ADDR_PDTMR:  next_rdata = {27'h0, pdtmr};
          cmp_pkg::ADDR_STATUS: next_rdata = {27'h0, pd_low_f,
                                  pwr_pend, soft_power_down,
                                  full_power_down, conv_busy};
          cmp_pkg::ADDR_START:  next_rdata = 32'h0;
          default: begin
            // averaged result read like a single one
            if (rb_ok(rd_ch, ctrl[cmp_pkg::CTRL_RB_LSB +: 2]))
              next_rdata = {20'h0, res[rd_ch]};
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl     <= cmp_pkg::CTRL_RST;
      alert    <= cmp_pkg::ALERT_RST;
      pdtmr    <= cmp_pkg::PDTMR_RST;
      rdata    <= 32'h0;
      start_wr <= 1'b0;
    end else begin
      ctrl     <= next_ctrl;
      alert    <= next_alert;
      pdtmr    <= next_pdtmr;
      rdata    <= next_rdata;
      start_wr <= next_start_wr;
    end
  end

  assign prdata  = rdata;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_ok(paddr);

  assign thermistor_common_termination = ctrl[cmp_pkg::CTRL_TERM];
  // code 01 drops input 5, code 10 drops inputs 5 and 3
  assign thermistor_alert_exclude = {1'b0, alert[1] | alert[0], 1'b0,
                                     alert[1], 2'h0};

  // power-down sequencing
  logic        pend_hw, next_pend_hw;
  logic [31:0] tick_div, next_tick_div;
  logic [4:0]  tick_cnt, next_tick_cnt;
  logic        hw_pd, next_hw_pd;
  logic        sw_pd, next_sw_pd;

  always_comb begin
    next_pwr_pend = pwr_pend;
    next_pend_hw  = pend_hw;
    next_tick_div = tick_div;
    next_tick_cnt = tick_cnt;
    next_hw_pd    = hw_pd & ~hw_rel;
    next_sw_pd    = sw_pd & ctrl[cmp_pkg::CTRL_SWPD];
    if (pwr_pend && (pend_hw ? hw_rel : ~ctrl[cmp_pkg::CTRL_SWPD]))
      next_pwr_pend = 1'b0;
    // whole ticks from control clock edges
    if (pwr_pend && ctrl_rise) begin
      if (tick_div == 32'(TICK_EDGES - 1)) begin
        next_tick_div = 32'h0;
        next_tick_cnt = tick_cnt + 5'h1;
        if (tick_cnt + 5'h1 == pdtmr) begin
          next_pwr_pend = 1'b0;
          next_hw_pd    = hw_pd | pend_hw;
          next_sw_pd    = sw_pd | ~pend_hw;
        end
      end else begin
        next_tick_div = tick_div + 32'h1;
      end
    end
    if (hw_req || sw_req) begin
      if (pdtmr == cmp_pkg::PDTMR_RST) begin
        next_pwr_pend = 1'b0;
        next_hw_pd    = next_hw_pd | hw_req;
        next_sw_pd    = next_sw_pd | sw_req;
      end else begin
        next_pwr_pend = 1'b1;
        next_pend_hw  = hw_req;
        next_tick_div = 32'h0;
        next_tick_cnt = 5'h0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_pend <= 1'b0;
      pend_hw  <= 1'b0;
      tick_div <= 32'h0;
      tick_cnt <= 5'h0;
      hw_pd    <= 1'b0;
      sw_pd    <= 1'b0;
    end else begin
      pwr_pend <= next_pwr_pend;
      pend_hw  <= next_pend_hw;
      tick_div <= next_tick_div;
      tick_cnt <= next_tick_cnt;
      hw_pd    <= next_hw_pd;
      sw_pd    <= next_sw_pd;
    end
  end

  // full power-down; soft keeps regulator, reference and chain
  assign full_power_down = hw_pd;
  assign soft_power_down = sw_pd & ~hw_pd;
  assign balance_off     = hw_pd | sw_pd;

  // conversion sequencer
  cmp_pkg::cmp_seq_state_t state, next_state;
  logic [3:0]            chan, next_chan;
  logic [2:0]            rep, next_rep;
  logic [14:0]           acc, next_acc;
  cmp_pkg::cmp_adc_req_t req, next_req;
  logic [11:0]           next_res [cmp_pkg::NUM_RES];
  logic [1:0]            conv_sel, avg_sel;
  logic [14:0]           sum;

  assign conv_sel = ctrl[cmp_pkg::CTRL_CONV_LSB +: 2];
  assign avg_sel  = ctrl[cmp_pkg::CTRL_AVG_LSB +: 2];
  assign sum      = acc + {3'h0, adc_data};

  always_comb begin
    next_state = state;
    next_chan  = chan;
    next_rep   = rep;
    next_acc   = acc;
    next_req   = req;
    next_res   = res;
    next_req.start = 1'b0;
    case (state)
      cmp_pkg::SQ_IDLE: begin
        if (convert_start_n_pin_fall || start_wr) begin
          // self-test code converts the self-test channel only
          next_chan  = (conv_sel == cmp_pkg::CONV_SELF) ? cmp_pkg::CH_SELF
                                                        : cmp_pkg::CH_V6;
          next_rep   = 3'h0;
          next_acc   = 15'h0;
          next_state = cmp_pkg::SQ_ISSUE;
        end
      end
      cmp_pkg::SQ_ISSUE: begin
        next_req.start   = 1'b1;
        next_req.channel = chan;
        // acquisition code passed to the converter
        next_req.acq     = ctrl[cmp_pkg::CTRL_ACQ_LSB +: 2];
        next_state       = cmp_pkg::SQ_WAIT;
      end
      cmp_pkg::SQ_WAIT: begin
        if (adc_done) begin
          next_state = cmp_pkg::SQ_ISSUE;
          // repeat on this channel before moving on
          if (rep == 3'((4'h1 << avg_sel) - 4'h1)) begin
            next_res[chan] = 12'(sum >> avg_sel);
            next_acc  = 15'h0;
            next_rep  = 3'h0;
            next_chan = next_ch(chan, conv_sel);
            if (next_chan == cmp_pkg::CH_NONE)
              next_state = cmp_pkg::SQ_IDLE;
          end else begin
            next_acc = sum;
            next_rep = rep + 3'h1;
          end
        end
      end
      default: next_state = cmp_pkg::SQ_IDLE;
    endcase
    if (hw_pd || sw_pd)
      next_state = cmp_pkg::SQ_IDLE;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= cmp_pkg::SQ_IDLE;
      chan  <= 4'h0;
      rep   <= 3'h0;
      acc   <= 15'h0;
      req   <= '0;
      for (int i = 0; i < cmp_pkg::NUM_RES; i++)
        res[i] <= 12'h000;
    end else begin
      state <= next_state;
      chan  <= next_chan;
      rep   <= next_rep;
      acc   <= next_acc;
      req   <= next_req;
      res   <= next_res;
    end
  end

  assign adc_req   = req;
  assign conv_busy = (state != cmp_pkg::SQ_IDLE);

endmodule // cmp_conv_power_ctrl

/* sim/cmp_props_properties.sv */
// port assertions of the converter and power-down control
`timescale 1ns/1ps
module cmp_props #(
  parameter int PD_LOW_CYCLES = 20
) (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic [7:0]            paddr,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [31:0]           pwdata,
  input wire logic                  power_down_n_pin,
  input wire cmp_pkg::cmp_adc_req_t adc_req,
  input wire logic                  full_power_down,
  input wire logic                  soft_power_down,
  input wire logic                  balance_off
);
  logic [15:0] ctrl;
  logic [4:0]  tmr;
  int          lo_n;
  int          hi_n;
  logic        wr_c;
  logic        sw_req;
  assign wr_c = psel && penable && pwrite && paddr == cmp_pkg::ADDR_CTRL;
  assign sw_req = wr_c && pwdata[8] && !ctrl[8];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= '0;
      tmr <= '0;
      lo_n <= 0;
      hi_n <= 0;
    end else begin
      if (wr_c) begin
        ctrl <= pwdata[15:0];
      end
      if (psel && penable && pwrite && paddr == cmp_pkg::ADDR_PDTMR) begin
        tmr <= pwdata[4:0];
      end
      lo_n <= power_down_n_pin ? 0 : lo_n + 1;
      hi_n <= power_down_n_pin ? hi_n + 1 : 0;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_pin_filter: assert property (
    $rose(full_power_down) |-> lo_n >= PD_LOW_CYCLES)
    else $error("power-down entered on a short low pin");
  a_pin_release: assert property (
    $fell(full_power_down) |-> hi_n >= cmp_pkg::PD_HIGH_CYC)
    else $error("power-down left on a short high pin");
  a_balance_off: assert property (
    soft_power_down || full_power_down |-> balance_off)
    else $error("balance outputs on while powered down");
  a_zero_delay: assert property (
    sw_req && tmr == 5'h00 |-> ##[1:2] soft_power_down || full_power_down)
    else $error("no immediate power-down with zero delay");
  a_timer_wait: assert property (
    sw_req && tmr != 5'h00 |=> !soft_power_down [*8])
    else $error("power-down before the delay ran out");
  a_volt_only: assert property (
    adc_req.start && ctrl[15:14] == cmp_pkg::CONV_VOLT
    |-> adc_req.channel <= cmp_pkg::CH_V6)
    else $error("temperature converted in voltage-only mode");
  a_odd_therm: assert property (
    adc_req.start && ctrl[15:14] == cmp_pkg::CONV_ODD
    && adc_req.channel >= cmp_pkg::CH_T1
    |-> adc_req.channel inside {4'h6, 4'h8, 4'ha})
    else $error("even thermistor converted in odd mode");
  a_self_only: assert property (
    adc_req.start && ctrl[15:14] == cmp_pkg::CONV_SELF
    |-> adc_req.channel == cmp_pkg::CH_SELF)
    else $error("input converted in self-test mode");
  a_acq_field: assert property (
    adc_req.start |-> adc_req.acq == ctrl[6:5])
    else $error("acquisition code differs from control");
endmodule // cmp_props

bind cmp_conv_power_ctrl cmp_props #(.PD_LOW_CYCLES(PD_LOW_CYCLES)) chk_u (
  .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
  .power_down_n_pin, .adc_req, .full_power_down, .soft_power_down,
  .balance_off);

/* sim/cmp_adc_model.sv */
// converter model that answers each start with a tagged sample
`timescale 1ns/1ps
module cmp_adc_model (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire cmp_pkg::cmp_adc_req_t adc_req,
  output logic                       adc_done,
  output logic [11:0]                adc_data
);
  logic [3:0] seen[$];
  logic [3:0] last_ch;
  logic [3:0] rep;
  int         wait_n;
  int         req_n;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_done <= 1'b0;
      adc_data <= 12'h000;
      last_ch <= cmp_pkg::CH_NONE;
      rep <= 4'h0;
      wait_n <= -1;
      req_n <= 0;
    end else begin
      adc_done <= 1'b0;
      // data lines toggle outside a valid sample
      adc_data <= ~adc_data;
      if (adc_req.start) begin
        seen.push_back(adc_req.channel);
        rep <= (adc_req.channel == last_ch) ? rep + 4'h1 : 4'h0;
        last_ch <= adc_req.channel;
        // prompt and slow answers alternate
        wait_n <= req_n[0] ? 6 : 0;
        req_n <= req_n + 1;
      end else if (wait_n == 0) begin
        adc_done <= 1'b1;
        adc_data <= {last_ch, 4'h0, rep};
        wait_n <= -1;
      end else if (wait_n > 0) begin
        wait_n <= wait_n - 1;
      end
    end
  end
endmodule // cmp_adc_model

/* sim/testbench.sv */
// bench of the converter and power-down control
`timescale 1ns/1ps
module testbench;
  logic        pclk;
  logic        presetn;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pd_n;
  logic        cs_n;
  logic        ctrl_clk;
  logic        adc_done;
  logic [11:0] adc_data;
  logic        busy;
  logic        term;
  logic [5:0]  excl;
  logic        full_pd;
  logic        soft_pd;
  logic        bal_off;
  logic [31:0] rdat;
  logic        rerr;
  logic [3:0]  exp_q[$];
  int          mismatches;
  int          checked;
  int          n;
  cmp_pkg::cmp_adc_req_t adc_req;

  always #2.5 pclk = ~pclk;
  initial begin
    ctrl_clk = 1'b0;
    #1.3;
    forever #80 ctrl_clk = ~ctrl_clk;
  end

  cmp_conv_power_ctrl #(.PD_LOW_CYCLES(20), .TICK_EDGES(4)) dut_u (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_down_n_pin(pd_n), .convert_start_n_pin(cs_n),
    .ctrl_clk(ctrl_clk), .adc_done(adc_done), .adc_data(adc_data),
    .adc_req(adc_req), .conv_busy(busy),
    .thermistor_common_termination(term),
    .thermistor_alert_exclude(excl), .full_power_down(full_pd),
    .soft_power_down(soft_pd), .balance_off(bal_off));
  cmp_adc_model model_u (.pclk(pclk), .presetn(presetn),
    .adc_req(adc_req), .adc_done(adc_done), .adc_data(adc_data));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 100) begin
      k++;
      @(posedge pclk);
    end
    if (k == 100) begin
      mismatches++;
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_busy(input logic v);
    int k;
    k = 0;
    while (busy !== v && k < 3000) begin
      k++;
      @(posedge pclk);
    end
    if (k == 3000) begin
      mismatches++;
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge pclk);
    mismatches++;
    end_sim;
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    paddr = 8'h00;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
    pd_n = 1'b1;
    cs_n = 1'b1;
    mismatches = 0;
    checked = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(cmp_pkg::ADDR_CTRL, 1'b0, 32'h0);
    chk(rdat, 32'h0);
    apb(cmp_pkg::ADDR_PDTMR, 1'b0, 32'h0);
    chk(rdat, 32'h0);
    apb(8'h20, 1'b0, 32'h0);
    chk({rdat[30:0], rerr}, 32'h1);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      n = 1 << i;
      // pass 1 puts 01 in both conversion and readback fields
      apb(cmp_pkg::ADDR_CTRL, 1'b1,
          (i << 14) | (i << 12) | (i << 9) | (i << 5));
      repeat (18000) @(posedge pclk);
      if (i == 1) begin
        cs_n <= 1'b0;
        repeat (6) @(posedge pclk);
        cs_n <= 1'b1;
      end else begin
        apb(cmp_pkg::ADDR_START, 1'b1, 32'h1);
      end
      wait_busy(1'b1);
      wait_busy(1'b0);
      exp_q = {};
      if (i != 3) for (int c = 5; c >= 0; c--) exp_q.push_back(4'(c));
      for (int c = 6; c < 12; c++)
        if (i == 0 || (i == 1 && c % 2 == 0)) exp_q.push_back(4'(c));
      if (i == 3) exp_q.push_back(cmp_pkg::CH_SELF);
      foreach (exp_q[e]) begin
        repeat (n) chk(model_u.seen.pop_front(), exp_q[e]);
        apb(cmp_pkg::ADDR_RES + 8'(4 * exp_q[e]), 1'b0, 32'h0);
        chk(rdat, {exp_q[e], 8'h00} + ((n - 1) >> 1));
      end
      chk(model_u.seen.size(), 0);
      if (i == 2) begin
        apb(cmp_pkg::ADDR_RES + 8'h18, 1'b0, 32'h0);
        chk(rdat, 32'h0);
      end
      $display("test averaging %0d done", n);
    end
    apb(cmp_pkg::ADDR_CTRL, 1'b1, 32'h68);
    @(posedge pclk);
    chk(term, 1'b1);
    for (int j = 0; j < 3; j++) begin
      apb(cmp_pkg::ADDR_ALERT, 1'b1, j);
      @(posedge pclk);
      chk(excl, {1'b0, j != 0, 1'b0, j == 2, 2'b00});
    end
    $display("test termination and exclusion done");
    apb(cmp_pkg::ADDR_CTRL, 1'b1, 32'h100);
    repeat (2) @(posedge pclk);
    chk({soft_pd, bal_off, full_pd}, 3'b110);
    apb(cmp_pkg::ADDR_CTRL, 1'b1, 32'h0);
    repeat (2) @(posedge pclk);
    chk(soft_pd, 1'b0);
    apb(cmp_pkg::ADDR_PDTMR, 1'b1, 32'hff);
    apb(cmp_pkg::ADDR_PDTMR, 1'b0, 32'h0);
    chk(rdat, 32'h1f);
    apb(cmp_pkg::ADDR_PDTMR, 1'b1, 32'h2);
    apb(cmp_pkg::ADDR_CTRL, 1'b1, 32'h100);
    repeat (200) @(posedge pclk);
    chk(soft_pd, 1'b0);
    apb(cmp_pkg::ADDR_STATUS, 1'b0, 32'h0);
    chk(rdat, 32'h8);
    repeat (100) @(posedge pclk);
    chk(soft_pd, 1'b1);
    apb(cmp_pkg::ADDR_CTRL, 1'b1, 32'h0);
    apb(cmp_pkg::ADDR_PDTMR, 1'b1, 32'h0);
    $display("test software power-down done");
    pd_n <= 1'b0;
    repeat (10) @(posedge pclk);
    pd_n <= 1'b1;
    repeat (40) @(posedge pclk);
    chk(full_pd, 1'b0);
    pd_n <= 1'b0;
    repeat (40) @(posedge pclk);
    chk({full_pd, bal_off}, 2'b11);
    apb(cmp_pkg::ADDR_STATUS, 1'b0, 32'h0);
    chk(rdat, 32'h12);
    pd_n <= 1'b1;
    repeat (900) @(posedge pclk);
    chk(full_pd, 1'b1);
    repeat (200) @(posedge pclk);
    chk(full_pd, 1'b0);
    $display("test pin power-down done");
    end_sim;
  end
endmodule // testbench
